// File: logic/rpse_defs.svh
/*
 * Constants of the per-port status and error counter register group:
 * register offsets, field positions, reset values and port count.
 * Assumes it is included by bare name by every file that needs a figure.
 */
// Function
// - every host access to this group, except to register 0x4C itself, goes to the copy of the receive port named in register 0x4C.
// - each sensor status byte is read-only and is refreshed from the forward channel only.
// - the third sensor status byte holds the remote camera input status from the forward channel.
// - parity errors are counted in 16 bits, upper byte at 0x55 and lower byte at 0x56.
// - the parity count restarts from zero on a new receiver lock and on a read of the low byte.
// - a read of the low parity byte returns its value and then clears it.
// - the high parity byte never clears on its own read, only on a read of the low byte or on a new receiver lock.
// - the self-test error count is a read-only byte that resets to zero.
// - the back-channel configuration resets with upper nibble 1 and strap-given low bits.
`ifndef RPSE_DEFS_SVH
`define RPSE_DEFS_SVH

`define RPSE_NUM_PORTS        4
`define RPSE_ADDR_PORT_SEL    8'h4C
`define RPSE_ADDR_SENSOR_ONE  8'h52
`define RPSE_ADDR_SENSOR_TWO  8'h53
`define RPSE_ADDR_SENSOR_THR  8'h54
`define RPSE_ADDR_PAR_HIGH    8'h55
`define RPSE_ADDR_PAR_LOW     8'h56
`define RPSE_ADDR_BIST_COUNT  8'h57
`define RPSE_ADDR_BACK_CFG    8'h58

`define RPSE_PORT_SEL_RESET   8'h00
`define RPSE_PORT_SEL_LSB     0
`define RPSE_PORT_SEL_MSB     1
`define RPSE_STATUS_RESET     8'h00
`define RPSE_PAR_RESET        16'h0000
`define RPSE_PAR_MAX          16'hFFFF
`define RPSE_BIST_RESET       8'h00
`define RPSE_BIST_MAX         8'hFF
`define RPSE_BCC_RESET_HIGH   4'h1
`define RPSE_BCC_RESET_CRC    1'b1
`define RPSE_BCC_STRAP_MSB    2
`define RPSE_UNMAPPED_DATA    8'h00

`define RPSE_IDX_SENSOR_ONE   2'h1
`define RPSE_IDX_SENSOR_TWO   2'h2
`define RPSE_IDX_SENSOR_THR   2'h3

`endif

// File: logic/rpse_pkg.sv
/*
 * Types shared by the per-port status register group.
 * Assumes rpse_defs.svh supplies the figures.
 */
package rpse_pkg;

   typedef logic [7:0]  rpse_byte_t;
   typedef logic [15:0] rpse_count_t;
   typedef logic [1:0]  rpse_port_t;

endpackage : rpse_pkg

// File: logic/rpse_sync.sv
/*
 * Two-flop synchroniser for the per-port lock levels.
 * Assumes the inputs are levels from outside the mclk domain.
 */
`timescale 1ns/1ns
`include "rpse_defs.svh"

module rpse_sync
(
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          nrst,
   // Levels
   input  wire logic [`RPSE_NUM_PORTS-1:0]    level_async,
   output logic      [`RPSE_NUM_PORTS-1:0]    level_sync
);

   logic [`RPSE_NUM_PORTS-1:0] stage_one;

   // The first stage feeds only the second stage.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_one  <= '0;
         level_sync <= '0;
      end
      else
      begin
         stage_one  <= level_async;
         level_sync <= stage_one;
      end
   end

endmodule : rpse_sync

// File: logic/rpse_par_counter.sv
/*
 * Saturating 16-bit parity error counter of one receive port.
 * Assumes inc, clear are single-cycle strobes on mclk.
 */
`timescale 1ns/1ns
`include "rpse_defs.svh"

module rpse_par_counter
(
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   // Control
   input  wire logic                  inc,
   input  wire logic                  clear,
   // Count
   output rpse_pkg::rpse_count_t      count
);

   rpse_pkg::rpse_count_t next_count;
   rpse_pkg::rpse_count_t bumped;

   // Saturation keeps a long unread run from wrapping to a small, misleading value.
   assign bumped     = (count == `RPSE_PAR_MAX) ? count : count + 16'h0001;
   // An error in the clearing cycle is kept: the restarted count is one.
   assign next_count = clear ? (inc ? 16'h0001 : `RPSE_PAR_RESET)
                             : (inc ? bumped : count);

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         count <= `RPSE_PAR_RESET;
      else
         count <= next_count;
   end

endmodule : rpse_par_counter

// File: logic/rpse_regs.sv
/*
 * Per-receive-port register group: sensor status bytes from the forward
 * channel, 16-bit parity error count with read-clear, self-test error count,
 * back-channel configuration and the port-select register that steers
 * host accesses to one port copy.
 * Assumes the host register port carries decoded single-cycle read and
 * write strobes from the serial control interface, forward channel and
 * error strobes come from receiver logic on mclk, and lock levels are
 * asynchronous.
 */
`timescale 1ns/1ns
`include "rpse_defs.svh"

module rpse_regs
(
   // Clock and reset
   input  wire logic                              mclk,
   input  wire logic                              nrst,
   // Host register port
   input  wire logic [7:0]                        reg_addr,
   input  wire logic [7:0]                        reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output rpse_pkg::rpse_byte_t                   reg_rdata,
   output logic                                   reg_rvalid,
   // Forward channel status, per port
   input  wire logic [`RPSE_NUM_PORTS-1:0]        fc_sts_load,
   input  wire logic [2*`RPSE_NUM_PORTS-1:0]      fc_sts_index,
   input  wire logic [8*`RPSE_NUM_PORTS-1:0]      fc_sts_data,
   // Receiver events, per port
   input  wire logic [`RPSE_NUM_PORTS-1:0]        rx_lock_async,
   input  wire logic [`RPSE_NUM_PORTS-1:0]        par_err,
   input  wire logic [`RPSE_NUM_PORTS-1:0]        bist_err,
   input  wire logic [`RPSE_NUM_PORTS-1:0]        bist_clear,
   // Global controls
   input  wire logic                              parity_check_en,
   input  wire logic [`RPSE_BCC_STRAP_MSB:0]      bc_freq_strap,
   // Configuration outputs
   output rpse_pkg::rpse_byte_t                   port_select,
   output logic [8*`RPSE_NUM_PORTS-1:0]           back_channel_config
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding

   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
      addr_is = (addr == target);
   endfunction : addr_is

   wire rpse_pkg::rpse_port_t sel_port;
   wire                       wr_port_sel;
   wire                       wr_bcc;
   wire                       rd_par_low;

   assign sel_port    = port_select[`RPSE_PORT_SEL_MSB:`RPSE_PORT_SEL_LSB];
   assign wr_port_sel = reg_wr && addr_is(reg_addr, `RPSE_ADDR_PORT_SEL);
   assign wr_bcc      = reg_wr && addr_is(reg_addr, `RPSE_ADDR_BACK_CFG);
   assign rd_par_low  = reg_rd && addr_is(reg_addr, `RPSE_ADDR_PAR_LOW);

   ////////////////////////////////////////////////////////////////////////////
   // Port select and strap capture

   logic strap_taken;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         port_select <= `RPSE_PORT_SEL_RESET;
      else if (wr_port_sel)
         port_select <= reg_wdata;
   end

   // The strap level is caught on the first edge after reset release.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         strap_taken <= 1'b0;
      else
         strap_taken <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock synchroniser

   logic [`RPSE_NUM_PORTS-1:0] lock_sync;
   logic [`RPSE_NUM_PORTS-1:0] lock_prev;

   rpse_sync u_lock_sync
   (
      .mclk        (mclk),
      .nrst        (nrst),
      .level_async (rx_lock_async),
      .level_sync  (lock_sync)
   );

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         lock_prev <= '0;
      else
         lock_prev <= lock_sync;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-port copies

   rpse_pkg::rpse_byte_t  sensor_one  [`RPSE_NUM_PORTS];
   rpse_pkg::rpse_byte_t  sensor_two  [`RPSE_NUM_PORTS];
   rpse_pkg::rpse_byte_t  sensor_thr  [`RPSE_NUM_PORTS];
   rpse_pkg::rpse_count_t par_count   [`RPSE_NUM_PORTS];
   rpse_pkg::rpse_byte_t  bist_count  [`RPSE_NUM_PORTS];
   rpse_pkg::rpse_byte_t  bcc_reg     [`RPSE_NUM_PORTS];

   genvar p;
   generate
      for (p = 0; p < `RPSE_NUM_PORTS; p++)
      begin : g_port
         wire       this_sel;
         wire       lock_rise;
         wire       par_clear;
         wire       par_inc;
         wire [1:0] sts_idx;
         wire [7:0] sts_byte;

         assign this_sel  = (sel_port == 2'(p));
         assign lock_rise = lock_sync[p] && !lock_prev[p];
         assign par_clear = lock_rise || (rd_par_low && this_sel);
         assign par_inc   = par_err[p] && parity_check_en;
         assign sts_idx   = fc_sts_index[2*p +: 2];
         assign sts_byte  = fc_sts_data[8*p +: 8];

         rpse_par_counter u_par
         (
            .mclk  (mclk),
            .nrst  (nrst),
            .inc   (par_inc),
            .clear (par_clear),
            .count (par_count[p])
         );

         // Only the forward channel loads these; host writes never reach them.
         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
            begin
               sensor_one[p] <= `RPSE_STATUS_RESET;
               sensor_two[p] <= `RPSE_STATUS_RESET;
               sensor_thr[p] <= `RPSE_STATUS_RESET;
            end
            else if (fc_sts_load[p])
            begin
               if (sts_idx == `RPSE_IDX_SENSOR_ONE)
                  sensor_one[p] <= sts_byte;
               if (sts_idx == `RPSE_IDX_SENSOR_TWO)
                  sensor_two[p] <= sts_byte;
               if (sts_idx == `RPSE_IDX_SENSOR_THR)
                  sensor_thr[p] <= sts_byte;
            end
         end

         // A test error in the clearing cycle is kept as a count of one.
         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
               bist_count[p] <= `RPSE_BIST_RESET;
            else if (bist_clear[p])
               bist_count[p] <= bist_err[p] ? 8'h01 : `RPSE_BIST_RESET;
            else if (bist_err[p] && bist_count[p] != `RPSE_BIST_MAX)
               bist_count[p] <= bist_count[p] + 8'h01;
         end

         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
               bcc_reg[p] <= {`RPSE_BCC_RESET_HIGH, `RPSE_BCC_RESET_CRC, 3'h0};
            else if (!strap_taken)
               bcc_reg[p][`RPSE_BCC_STRAP_MSB:0] <= bc_freq_strap;
            else if (wr_bcc && this_sel)
               bcc_reg[p] <= reg_wdata;
         end

         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
               back_channel_config[8*p +: 8] <= {`RPSE_BCC_RESET_HIGH, `RPSE_BCC_RESET_CRC, 3'h0};
            else
               back_channel_config[8*p +: 8] <= bcc_reg[p];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   rpse_pkg::rpse_byte_t rd_mux;
   rpse_pkg::rpse_count_t sel_count;

   assign sel_count = par_count[sel_port];

   // The low byte is sampled before the clear lands in the same edge.
   assign rd_mux =
      addr_is(reg_addr, `RPSE_ADDR_PORT_SEL)   ? port_select          :
      addr_is(reg_addr, `RPSE_ADDR_SENSOR_ONE) ? sensor_one[sel_port] :
      addr_is(reg_addr, `RPSE_ADDR_SENSOR_TWO) ? sensor_two[sel_port] :
      addr_is(reg_addr, `RPSE_ADDR_SENSOR_THR) ? sensor_thr[sel_port] :
      addr_is(reg_addr, `RPSE_ADDR_PAR_HIGH)   ? sel_count[15:8]      :
      addr_is(reg_addr, `RPSE_ADDR_PAR_LOW)    ? sel_count[7:0]       :
      addr_is(reg_addr, `RPSE_ADDR_BIST_COUNT) ? bist_count[sel_port] :
      addr_is(reg_addr, `RPSE_ADDR_BACK_CFG)   ? bcc_reg[sel_port]    :
      `RPSE_UNMAPPED_DATA;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         reg_rdata  <= `RPSE_UNMAPPED_DATA;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

endmodule : rpse_regs

// File: sim/rpse_properties.sv
/* Assertions on the ports of the per-port register group.
   Assumes it is bound to rpse_regs and watches that module's ports only. */
`timescale 1ns/1ns

module rpse_chk
(
   // Clock and reset
   input wire logic                 mclk,
   input wire logic                 nrst,
   // Host port
   input wire logic [7:0]           reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire rpse_pkg::rpse_byte_t reg_rdata,
   input wire logic                 reg_rvalid,
   // Status and controls
   input wire logic [3:0]           fc_sts_load,
   input wire logic [7:0]           fc_sts_index,
   input wire logic [31:0]          fc_sts_data,
   input wire logic                 parity_check_en,
   input wire rpse_pkg::rpse_byte_t port_select,
   input wire logic [31:0]          back_channel_config
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Low byte read with the checker off, so no new error can sneak in.
   wire lo = reg_rd && reg_addr == 8'h56 && !parity_check_en;
   wire sel_wr = reg_wr && reg_addr == 8'h4C;

   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read got no answer");
   chk_answer_quiet: assert property (!reg_rd |=> !reg_rvalid)
      else $error("answer without read");
   chk_select_write: assert property (sel_wr |=> port_select == $past(reg_wdata))
      else $error("port select not written");
   chk_select_hold: assert property (!sel_wr |=> $stable(port_select))
      else $error("port select moved");
   chk_select_read: assert property (reg_rd && reg_addr == 8'h4C
      |=> reg_rdata == $past(port_select))
      else $error("port select read wrong");
   chk_unmapped_zero: assert property (reg_rd && reg_addr < 8'h4C |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_bcc_write: assert property (reg_wr && reg_addr == 8'h58 ##1 !reg_wr
      |=> back_channel_config[{port_select[1:0], 3'h0} +: 8] == $past(reg_wdata, 2))
      else $error("config write lost");
   chk_sensor_three: assert property ((fc_sts_load[0] && fc_sts_index[1:0] == 2'h3
      && port_select[1:0] == 2'h0) ##1 (reg_rd && reg_addr == 8'h54 && !fc_sts_load[0])
      |=> reg_rdata == $past(fc_sts_data[7:0], 2))
      else $error("third status byte wrong");
   chk_low_clears: assert property (lo ##1 lo |=> reg_rdata == 8'h00)
      else $error("low byte not cleared");
   chk_high_cleared: assert property (lo ##1 (reg_rd && reg_addr == 8'h55 && !parity_check_en)
      |=> reg_rdata == 8'h00)
      else $error("high byte not cleared");
endmodule : rpse_chk

bind rpse_regs rpse_chk chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .fc_sts_load(fc_sts_load), .fc_sts_index(fc_sts_index),
   .fc_sts_data(fc_sts_data), .parity_check_en(parity_check_en),
   .port_select(port_select), .back_channel_config(back_channel_config));

// File: sim/rpse_host.sv
/* Host controller model driving the register port, one strobe a cycle.
   Assumes calls start just after a rising edge of mclk. */
`timescale 1ns/1ns

module rpse_host
(
   // Clock
   input wire logic                 mclk,
   // Register port
   output logic [7:0]               reg_addr,
   output logic [7:0]               reg_wdata,
   output logic                     reg_wr,
   output logic                     reg_rd,
   output logic                     parity_check_en,
   input wire rpse_pkg::rpse_byte_t reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      parity_check_en = 1'b0;
   end

   // The strobe stays up at the end so that transfers may run back to back.
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge mclk);
      #1;
      q = reg_rdata;
   endtask : xfer

   // A released address is inverted so a stale value never looks valid.
   task automatic idle;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      @(posedge mclk);
      #1;
   endtask : idle

   // Counts are read only with the checker off, so both bytes belong together.
   task automatic check(input logic en);
      parity_check_en = en;
   endtask : check
endmodule : rpse_host

// File: sim/rpse_regs_tb.sv
/* Self-checking bench of the per-port register group.
   Assumes rpse_host drives the host port and the checker is bound. */
`timescale 1ns/1ns

module rx_port_status_error_counters_tb;
   logic                 mclk = 1'b0;
   logic                 nrst = 1'b0;
   logic [3:0]           fc_sts_load = 4'h0;
   logic [7:0]           fc_sts_index = 8'h00;
   logic [31:0]          fc_sts_data = 32'h0;
   logic [3:0]           rx_lock_async = 4'h0;
   logic [3:0]           par_err = 4'h0;
   logic [3:0]           bist_err = 4'h0;
   logic [3:0]           bist_clear = 4'h0;
   wire logic [7:0]      reg_addr, reg_wdata;
   wire logic            reg_wr, reg_rd, parity_check_en, reg_rvalid;
   rpse_pkg::rpse_byte_t reg_rdata, port_select;
   logic [31:0]          back_channel_config;
   logic [2:0]           bc_freq_strap = 3'h6;
   int                   num_errors = 0;
   int                   cmp_count = 0;
   int                   cycles = 0;
   logic [15:0]          rows [9] = '{16'h4C00, 16'h5200, 16'h5300, 16'h5400,
                                      16'h5500, 16'h5600, 16'h5700, 16'h581E, 16'h1000};

   rpse_regs dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .fc_sts_load(fc_sts_load), .fc_sts_index(fc_sts_index), .fc_sts_data(fc_sts_data),
      .rx_lock_async(rx_lock_async), .par_err(par_err), .bist_err(bist_err),
      .bist_clear(bist_clear), .parity_check_en(parity_check_en),
      .bc_freq_strap(bc_freq_strap), .port_select(port_select),
      .back_channel_config(back_channel_config));
   rpse_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .parity_check_en(parity_check_en), .reg_rdata(reg_rdata));

   always #4 mclk = ~mclk;

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         num_errors++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic rd(input logic [7:0] a, e, input string n);
      logic [7:0] q;
      host.xfer(1'b0, a, 8'h00, q);
      chk(n, e, q);
      chk({n, " valid"}, 8'h01, {7'h00, reg_rvalid});
   endtask : rd

   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      host.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(8);
      nrst = 1'b1;
      cyc(3);
      foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0], "reset");
      host.idle();
      $display("done reset values");
      fc_sts_index = 8'hFF;
      fc_sts_data = 32'hA3A2A1A0;
      fc_sts_load = 4'hF;
      cyc(1);
      fc_sts_load = 4'h0;
      rd(8'h54, 8'hA0, "status three");
      fc_sts_index = 8'hAA;
      fc_sts_data = 32'hB3B2B1B0;
      fc_sts_load = 4'hF;
      cyc(1);
      fc_sts_load = 4'h0;
      for (int p = 0; p < 4; p++)
      begin
         wr(8'h4C, 8'(p));
         wr(8'h54, 8'hFF);
         rd(8'h54, 8'hA0 + 8'(p), "status steered");
         rd(8'h53, 8'hB0 + 8'(p), "status two");
      end
      wr(8'h4C, 8'h01);
      host.idle();
      $display("done status");
      host.check(1'b1);
      par_err = 4'h2;
      cyc(259);
      par_err = 4'h0;
      host.check(1'b0);
      rd(8'h55, 8'h01, "count high");
      rd(8'h55, 8'h01, "count high kept");
      rd(8'h56, 8'h03, "count low");
      rd(8'h56, 8'h00, "count low cleared");
      rd(8'h55, 8'h00, "count high cleared");
      host.idle();
      host.check(1'b1);
      par_err = 4'h3;
      cyc(5);
      par_err = 4'h0;
      rx_lock_async = 4'h2;
      cyc(4);
      host.check(1'b0);
      rd(8'h56, 8'h00, "lock clear");
      wr(8'h4C, 8'h00);
      rd(8'h56, 8'h05, "other port count");
      host.idle();
      $display("done parity");
      bist_err = 4'h4;
      cyc(3);
      bist_err = 4'h0;
      wr(8'h4C, 8'h02);
      rd(8'h57, 8'h03, "self test count");
      host.idle();
      bist_clear = 4'h4;
      cyc(1);
      bist_clear = 4'h0;
      rd(8'h57, 8'h00, "self test cleared");
      wr(8'h4C, 8'h03);
      wr(8'h58, 8'h5A);
      host.idle();
      rd(8'h58, 8'h5A, "config written");
      chk("config out", 8'h5A, back_channel_config[31:24]);
      chk("select out", 8'h03, port_select);
      wr(8'h4C, 8'h00);
      rd(8'h58, 8'h1E, "config other port");
      host.idle();
      $display("done counts and config");
      bc_freq_strap = 3'h2;
      bist_err = 4'h4;
      cyc(1);
      bist_err = 4'h0;
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
      cyc(2);
      rd(8'h4C, 8'h00, "select after reset");
      wr(8'h4C, 8'h03);
      rd(8'h58, 8'h1A, "config after reset");
      wr(8'h4C, 8'h02);
      rd(8'h57, 8'h00, "self test after reset");
      host.idle();
      $display("done mid-run reset");
      conclude();
   end
endmodule : rx_port_status_error_counters_tb
